/* ctf_pkg.sv */
// package for the core timer facilities block
// assumes a single core clock; constants and types only, no logic
package ctf_pkg;

  localparam int DEC_W      = 32;
  localparam int MSR_W      = 32;
  localparam int PC_W       = 32;
  localparam int PREFIX_W   = 23;
  localparam int OFFSET_W   = 9;
  localparam int ADDR_W     = 4;

  localparam logic [ADDR_W-1:0] ADDR_DEC    = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_TCR    = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_TSR    = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_MSR    = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_SPC    = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_SST    = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_VPR    = 4'h6;

  // decrement source codes
  localparam logic [1:0] SRC_ALWAYS = 2'h0;
  localparam logic [1:0] SRC_EV1    = 2'h1;
  localparam logic [1:0] SRC_TICK   = 2'h2;
  localparam logic [1:0] SRC_EV3    = 2'h3;

  // watchdog action codes
  localparam logic [1:0] WDA_NONE   = 2'h0;
  localparam logic [1:0] WDA_SOFT   = 2'h1;
  localparam logic [1:0] WDA_HARD   = 2'h2;
  localparam logic [1:0] WDA_HALT   = 2'h3;

  // vector offsets
  localparam logic [OFFSET_W-1:0] VEC_DEC = 9'h100;
  localparam logic [OFFSET_W-1:0] VEC_FIT = 9'h120;
  localparam logic [OFFSET_W-1:0] VEC_WDT = 9'h140;

  // timer control register fields (bit positions)
  localparam int TCR_SRC_LO  = 0;
  localparam int TCR_FP_LO   = 2;
  localparam int TCR_WP_LO   = 4;
  localparam int TCR_CIE     = 6;
  localparam int TCR_FIE     = 7;
  localparam int TCR_WIE     = 8;
  localparam int TCR_WRC_LO  = 9;

  // timer status register fields
  localparam int TSR_DIS     = 0;
  localparam int TSR_FIS     = 1;
  localparam int TSR_WIS     = 2;
  localparam int TSR_ENW     = 3;
  localparam int TSR_WRS_LO  = 4;

  // machine state bits cleared on timer interrupt entry (ext enable included)
  localparam logic [MSR_W-1:0] MSR_CLR_MASK = 32'h0000_7ffc;
  localparam int MSR_EE_BIT   = 2;

  typedef struct packed {
    logic [1:0] src;
    logic [1:0] fit_sel;
    logic [1:0] wdt_sel;
    logic       cnt_en;
    logic       fit_en;
    logic       wdt_en;
    logic [1:0] wdt_act;
  } ctf_ctrl_t;

  typedef struct packed {
    logic [1:0] wdt_rec;
    logic       arm;
    logic       wdt_flag;
    logic       fit_flag;
    logic       cnt_flag;
  } ctf_stat_t;

  typedef struct packed {
    logic              take;
    logic [PC_W-1:0]   pc;
  } ctf_vec_t;

endpackage : ctf_pkg

/* ctf_sync.sv */
// two-flop synchroniser bank for event inputs
// assumes inputs arrive from outside the core clock domain
`timescale 1ns/1ns
`default_nettype none
module ctf_sync #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : ctf_sync
`default_nettype wire

/* ctf_timer.sv */
// core timer facilities: down-counter, interval and watchdog events,
// interrupt gating, priority and vectored entry
// assumes a single core clock; event pins are asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module ctf_timer
  import ctf_pkg::*;
(
  input  wire logic                  CORE_CLK,
  input  wire logic                  RESET,
  input  wire logic                  CLK_EN,
  input  wire logic                  DEC_TICK,
  input  wire logic [3:0]            TIMER_EVENT,
  input  wire logic                  EXT_INT,
  input  wire logic                  INSN_BOUNDARY,
  input  wire logic [ctf_pkg::PC_W-1:0] NEXT_PC,
  input  wire logic [ctf_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic [31:0]           REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic      [31:0]           REG_RDATA,
  output ctf_pkg::ctf_vec_t          INT_ENTRY,
  output logic                       EXT_INT_TAKE,
  output logic                       WDT_TIMEOUT,
  output logic [1:0]                 WDT_ACTION,
  output logic [ctf_pkg::MSR_W-1:0]  MSR_OUT
);

  typedef enum logic [3:0] {
    PICK_NONE = 4'b0001,
    PICK_WDT  = 4'b0010,
    PICK_EXT  = 4'b0100,
    PICK_LOW  = 4'b1000
  } ctf_pick_t;

  logic [4:0]          ev_sync;
  logic                tick;
  logic [3:0]          ev;
  ctf_ctrl_t           ctrl;
  ctf_stat_t           stat;
  logic [DEC_W-1:0]    counter;
  logic [MSR_W-1:0]    machine_state_reg;
  logic [PC_W-1:0]     saved_pc;
  logic [MSR_W-1:0]    saved_state;
  logic [PREFIX_W-1:0] vec_prefix;
  logic                prev_msb;

  ctf_sync #(.W(5)) u_sync (
    .clk (CORE_CLK),
    .rst (RESET),
    .ce  (CLK_EN),
    .d   ({DEC_TICK, TIMER_EVENT}),
    .q   (ev_sync)
  );

  assign tick = ev_sync[4];
  assign ev   = ev_sync[3:0];

  function automatic logic sel4(input logic [3:0] v, input logic [1:0] s);
    sel4 = v[s];
  endfunction : sel4

  function automatic logic wr_at(input logic wr, input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] r);
    wr_at = wr && (a == r);
  endfunction : wr_at

  // decrement source; absent sources simply leave it idle
  wire dec_cond = (ctrl.src == SRC_ALWAYS) ? 1'b1 :
                  (ctrl.src == SRC_TICK)   ? tick :
                  (ctrl.src == SRC_EV1)    ? ev[1] : ev[3];
  wire fit_ev   = sel4(ev, ctrl.fit_sel);
  wire wdt_ev   = sel4(ev, ctrl.wdt_sel);

  wire wr_dec   = wr_at(REG_WR, REG_ADDR, ADDR_DEC);
  wire wr_tcr   = wr_at(REG_WR, REG_ADDR, ADDR_TCR);
  wire wr_tsr   = wr_at(REG_WR, REG_ADDR, ADDR_TSR);
  wire wr_msr   = wr_at(REG_WR, REG_ADDR, ADDR_MSR);
  wire wr_vpr   = wr_at(REG_WR, REG_ADDR, ADDR_VPR);

  wire clr_dis  = wr_tsr && REG_WDATA[TSR_DIS];
  wire clr_fis  = wr_tsr && REG_WDATA[TSR_FIS];
  wire clr_wis  = wr_tsr && REG_WDATA[TSR_WIS];
  wire clr_enw  = wr_tsr && REG_WDATA[TSR_ENW];

  // wraps to all ones naturally at zero
  wire [DEC_W-1:0] next_counter = wr_dec ? REG_WDATA :
                   dec_cond ? counter - 1'b1 : counter;
  wire msb_rise = !prev_msb && counter[DEC_W-1];

  wire wdt_unarmed = wdt_ev && !stat.arm;
  wire wdt_set     = wdt_ev && stat.arm;
  wire wdt_fire    = wdt_set && stat.wdt_flag &&
                     (ctrl.wdt_act != WDA_NONE);

  wire ee      = machine_state_reg[MSR_EE_BIT];
  wire wdt_req = stat.wdt_flag && ctrl.wdt_en && ee &&
                 (ctrl.wdt_act == WDA_NONE);
  wire ext_req = EXT_INT && ee;
  wire fit_req = stat.fit_flag && ctrl.fit_en && ee;
  wire cnt_req = stat.cnt_flag && ctrl.cnt_en && ee;

  // if chain rather than a conditional of enum members, so that no
  // tool has to convert an int-typed result back to the state type
  ctf_pick_t pick;
  always_comb begin
    if (!INSN_BOUNDARY)
      pick = PICK_NONE;
    else if (wdt_req)
      pick = PICK_WDT;
    else if (ext_req)
      pick = PICK_EXT;
    else if (fit_req || cnt_req)
      pick = PICK_LOW;
    else
      pick = PICK_NONE;
  end

  logic [OFFSET_W-1:0] vec_off;
  always_comb begin
    unique case (pick)
      PICK_WDT: vec_off = VEC_WDT;
      PICK_LOW: vec_off = fit_req ? VEC_FIT : VEC_DEC;
      default:  vec_off = '0;
    endcase
  end

  wire take_timer = (pick == PICK_WDT) || (pick == PICK_LOW);

  // entry clears listed bits, others kept
  wire [MSR_W-1:0] next_msr = take_timer ? (machine_state_reg & ~MSR_CLR_MASK) :
                              wr_msr ? REG_WDATA : machine_state_reg;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      counter  <= '0;
      prev_msb <= 1'b0;
    end else if (CLK_EN) begin
      counter  <= next_counter;
      prev_msb <= counter[DEC_W-1];
    end
  end

  // clear wins over hardware set for all three flags
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      stat <= '0;
    end else if (CLK_EN) begin
      stat.cnt_flag <= !clr_dis && (stat.cnt_flag || msb_rise);
      stat.fit_flag <= !clr_fis && (stat.fit_flag || fit_ev);
      stat.wdt_flag <= !clr_wis && (stat.wdt_flag || wdt_set);
      stat.arm      <= !clr_enw && (stat.arm || wdt_unarmed);
      if (wdt_fire)
        stat.wdt_rec <= ctrl.wdt_act;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ctrl <= '0;
    end else if (CLK_EN) begin
      if (wr_tcr)
        ctrl <= REG_WDATA[TCR_WRC_LO+1:0];
      if (wdt_fire)
        ctrl.wdt_act <= WDA_NONE;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      machine_state_reg         <= '0;
      saved_pc    <= '0;
      saved_state <= '0;
      vec_prefix  <= '0;
    end else if (CLK_EN) begin
      machine_state_reg <= next_msr;
      if (wr_vpr)
        vec_prefix <= REG_WDATA[PC_W-1:PC_W-PREFIX_W];
      if (take_timer) begin
        saved_pc    <= NEXT_PC;
        saved_state <= machine_state_reg;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      INT_ENTRY    <= '0;
      EXT_INT_TAKE <= 1'b0;
      WDT_TIMEOUT  <= 1'b0;
      WDT_ACTION   <= WDA_NONE;
      REG_RDATA    <= '0;
    end else if (CLK_EN) begin
      INT_ENTRY.take <= take_timer;
      INT_ENTRY.pc   <= {vec_prefix, vec_off};
      EXT_INT_TAKE   <= (pick == PICK_EXT);
      WDT_TIMEOUT    <= wdt_fire;
      WDT_ACTION     <= wdt_fire ? ctrl.wdt_act : WDA_NONE;
      REG_RDATA      <= '0;
      if (REG_RD) begin
        unique case (REG_ADDR)
          ADDR_DEC: REG_RDATA <= counter;
          ADDR_TCR: REG_RDATA <= {21'h0, ctrl};
          ADDR_TSR: REG_RDATA <= {26'h0, stat};
          ADDR_MSR: REG_RDATA <= machine_state_reg;
          ADDR_SPC: REG_RDATA <= saved_pc;
          ADDR_SST: REG_RDATA <= saved_state;
          ADDR_VPR: REG_RDATA <= {vec_prefix, 9'h0};
          default:  REG_RDATA <= '0;
        endcase
      end
    end
  end

  assign MSR_OUT = machine_state_reg;

  a_clear_wins: assert property (@(posedge CORE_CLK) disable iff (RESET)
    CLK_EN && clr_dis |=> !stat.cnt_flag)
    else $error("counter flag survived clear");
  a_fit_clear: assert property (@(posedge CORE_CLK) disable iff (RESET)
    CLK_EN && clr_fis |=> !stat.fit_flag)
    else $error("interval flag survived clear");
  a_wrap_ones: assert property (@(posedge CORE_CLK) disable iff (RESET)
    CLK_EN && !wr_dec && dec_cond && counter == '0
    |=> counter == '1)
    else $error("counter did not wrap");
  a_msb_flag: assert property (@(posedge CORE_CLK) disable iff (RESET)
    CLK_EN && msb_rise && !clr_dis |=> stat.cnt_flag)
    else $error("msb rise missed");
  a_wdt_arm: assert property (@(posedge CORE_CLK) disable iff (RESET)
    CLK_EN && wdt_unarmed && !clr_wis |=> !$rose(stat.wdt_flag))
    else $error("unarmed event set flag");
  a_wdt_fire: assert property (@(posedge CORE_CLK) disable iff (RESET)
    CLK_EN && wdt_fire |=> WDT_TIMEOUT && ctrl.wdt_act == WDA_NONE)
    else $error("watchdog action missing");
  a_vec_entry: assert property (@(posedge CORE_CLK) disable iff (RESET)
    CLK_EN && take_timer |=> INT_ENTRY.take && !machine_state_reg[MSR_EE_BIT])
    else $error("entry left ext enable set");
  a_prio_wdt: assert property (@(posedge CORE_CLK) disable iff (RESET)
    CLK_EN && INSN_BOUNDARY && wdt_req
    |=> INT_ENTRY.pc[OFFSET_W-1:0] == VEC_WDT && !EXT_INT_TAKE)
    else $error("watchdog priority lost");
  a_gate_ee: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !ee |-> !take_timer)
    else $error("timer taken with ext disabled");

endmodule : ctf_timer
`default_nettype wire

/* ctf_src_model.sv */
// partner model: the outside time sources, a tick line and four event lines
// assumes the core clock domain; levels change just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module ctf_src_model (
  input  wire logic       clk,
  output logic            tick,
  output logic [3:0]      ev
);
  initial begin
    tick = 1'b0;
    ev   = 4'h0;
  end
  // one active cycle per event with an idle cycle after it, so each
  // event stays distinct after the synchroniser; line 4 means the tick
  task automatic pulse(input int line, input int n);
    repeat (n) begin
      @(posedge clk);
      if (line > 3) begin
        tick <= 1'b1;
      end else begin
        ev[line] <= 1'b1;
      end
      @(posedge clk);
      tick <= 1'b0;
      ev   <= 4'h0;
    end
  endtask : pulse
endmodule : ctf_src_model
`default_nettype wire

/* core_timer_facilities_tb_top.sv */
// testbench for the timer block: register port, event sources, entries
// assumes clock enable and instruction boundary stay high throughout
`timescale 1ns/1ns
`default_nettype none
module core_timer_facilities_tb_top;
  import ctf_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              ext_int = 1'b0;
  logic [PC_W-1:0]   next_pc = '0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0]       wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [31:0]       rdata, r, v, pfx, pc, machine_state_reg;
  logic              tick, wdt_to, ext_take;
  logic [3:0]        ev;
  logic [1:0]        wdt_act;
  logic [2:0]        hits;
  ctf_vec_t          ent;
  int                fails = 0;
  int                checks_done = 0;
  int                cyc = 0;
  int                n;
  logic [1:0]        srcs [3] = '{SRC_TICK, SRC_EV1, SRC_EV3};
  int                lines [3] = '{4, 1, 3};
  logic [8:0]        offs [5] = '{VEC_WDT, 9'h0, VEC_FIT, VEC_DEC, 9'h0};
  logic [2:0]        hexp [5] = '{3'h1, 3'h2, 3'h1, 3'h1, 3'h0};

  always #2 clk = ~clk;
  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  ctf_src_model src_u (.clk(clk), .tick(tick), .ev(ev));

  ctf_timer dut_u (
    .CORE_CLK(clk), .RESET(rst), .CLK_EN(1'b1), .DEC_TICK(tick),
    .TIMER_EVENT(ev), .EXT_INT(ext_int), .INSN_BOUNDARY(1'b1),
    .NEXT_PC(next_pc), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .INT_ENTRY(ent),
    .EXT_INT_TAKE(ext_take), .WDT_TIMEOUT(wdt_to), .WDT_ACTION(wdt_act),
    .MSR_OUT(machine_state_reg)
  );

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask : rd_reg

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // records which one-cycle pulses appear over the next ten cycles
  task automatic watch();
    pc   = '0;
    hits = '0;
    repeat (10) begin
      @(posedge clk);
      #1;
      if (ent.take === 1'b1) begin
        hits[0] = 1'b1;
        pc = ent.pc;
      end
      if (ext_take === 1'b1) hits[1] = 1'b1;
      if (wdt_to === 1'b1) begin
        hits[2] = 1'b1;
        pc = {30'h0, wdt_act};
      end
    end
  endtask : watch

  task automatic print_verdict();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    v = $urandom(82323);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ADDR_TCR);
    chk(r, 32'h0);
    for (int i = 0; i < 3; i++) begin
      v = $urandom;
      n = $urandom_range(1, 6);
      wr_reg(ADDR_TCR, {21'h0, srcs[i], 9'h0});
      wr_reg(ADDR_DEC, v);
      rd_reg(ADDR_DEC);
      chk(r, v);
      // line 0 never feeds the counter, so it must be ignored
      src_u.pulse(0, 2);
      src_u.pulse(lines[i], n);
      repeat (4) @(posedge clk);
      rd_reg(ADDR_DEC);
      chk(r, v - n);
    end
    wr_reg(ADDR_TCR, 32'h0);
    // drop any flag left by the random loads so the wrap alone must set it
    wr_reg(ADDR_TSR, 32'h1);
    wr_reg(ADDR_DEC, 32'h0);
    repeat (8) @(posedge clk);
    rd_reg(ADDR_DEC);
    chk({28'h0, r[31:28]}, 32'hf);
    rd_reg(ADDR_TSR);
    chk({31'h0, r[0]}, 32'h1);
    wr_reg(ADDR_TSR, 32'h1);
    rd_reg(ADDR_TSR);
    chk({31'h0, r[0]}, 32'h0);
    for (int a = 1; a < 4; a++) begin
      wr_reg(ADDR_TCR, {21'h0, SRC_TICK, 7'h0, a[1:0]});
      wr_reg(ADDR_TSR, 32'hf);
      src_u.pulse(0, 1);
      repeat (4) @(posedge clk);
      rd_reg(ADDR_TSR);
      // line 0 also feeds the interval flag, selection field left at 0
      chk({28'h0, r[3:0]}, 32'ha);
      src_u.pulse(0, 1);
      repeat (4) @(posedge clk);
      rd_reg(ADDR_TSR);
      chk({28'h0, r[3:0]}, 32'he);
      src_u.pulse(0, 1);
      watch();
      chk({29'h0, hits}, 32'h4);
      chk(pc, a);
      rd_reg(ADDR_TCR);
      chk(r, {21'h0, SRC_TICK, 9'h0});
      rd_reg(ADDR_TSR);
      chk({30'h0, r[5:4]}, a);
    end
    // every source pending at once, then serviced one by one
    pfx = $urandom;
    next_pc <= $urandom;
    wr_reg(ADDR_VPR, pfx);
    wr_reg(ADDR_TCR, 32'h51c);
    wr_reg(ADDR_TSR, 32'hf);
    src_u.pulse(0, 2);
    src_u.pulse(2, 1);
    wr_reg(ADDR_DEC, 32'h0);
    src_u.pulse(4, 1);
    repeat (4) @(posedge clk);
    rd_reg(ADDR_DEC);
    chk(r, 32'hffff_ffff);
    ext_int <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      if (k == 4) wr_reg(ADDR_TCR, 32'h50c);
      wr_reg(ADDR_MSR, 32'hffff_ffff);
      watch();
      chk({29'h0, hits}, hexp[k]);
      chk(pc, (hexp[k] == 3'h1) ? {pfx[31:9], offs[k]} : 32'h0);
      // only timer entries touch the state and save registers
      if (hits == 3'h1) begin
        chk(machine_state_reg, 32'hffff_8003);
        rd_reg(ADDR_SST);
        chk(r, 32'hffff_ffff);
        rd_reg(ADDR_SPC);
        chk(r, next_pc);
      end
      if (k == 0) wr_reg(ADDR_TSR, 32'h4);
      if (k == 1) ext_int <= 1'b0;
      if (k == 2) wr_reg(ADDR_TSR, 32'h2);
    end
    // down-counter: stale flag cleared before the timeout is loaded,
    // so the only entry is the one the programmed timeout causes
    wr_reg(ADDR_MSR, 32'h0);
    wr_reg(ADDR_TCR, 32'h0);
    wr_reg(ADDR_DEC, 32'hffff_ffff);
    wr_reg(ADDR_TSR, 32'h1);
    wr_reg(ADDR_DEC, 32'h14);
    wr_reg(ADDR_TCR, 32'h10);
    wr_reg(ADDR_MSR, 32'hffff_ffff);
    // wrap comes 21 cycles after the load, entry two cycles later
    repeat (12) @(posedge clk);
    watch();
    chk({29'h0, hits}, 32'h1);
    chk(pc, {pfx[31:9], VEC_DEC});
    chk(machine_state_reg, 32'hffff_8003);
    print_verdict();
  end
endmodule : core_timer_facilities_tb_top
`default_nettype wire
